// >>> design/frc_pkg.sv
// Package for the fault retry controller: trip layout, class masks, timing.
// Assumes one 250 MHz system clock and detectors that hold a trip level until cleared.
package frc_pkg;

    // Timing
    localparam int unsigned FRC_CLK_HZ       = 250_000_000;
    localparam int unsigned FRC_TICK_MS      = 100;
    localparam int unsigned FRC_TICK_CYCLES  = FRC_CLK_HZ / 1000 * FRC_TICK_MS;
    localparam int unsigned FRC_WAIT_W       = 13;
    localparam int unsigned FRC_TICKS_W      = 15;
    localparam logic [12:0] FRC_WAIT_MIN     = 13'h0001;
    localparam logic [12:0] FRC_WAIT_MAX     = 13'h1770;
    localparam logic [12:0] FRC_WAIT_RESET   = 13'h000a;
    localparam logic [14:0] FRC_TICKS_MAX    = 15'h7fff;

    // Settings encodings
    localparam logic [7:0]  FRC_LIMIT_OFFSET = 8'h64;
    localparam logic [7:0]  FRC_LIMIT_QUIET  = 8'h0a;
    localparam logic [13:0] FRC_COAST_OFF    = 14'h270f;
    localparam logic [7:0]  FRC_FUNC_POS     = 8'h40;
    localparam logic [7:0]  FRC_FUNC_NEG     = 8'ha4;

    // Trip bit positions
    localparam int unsigned FRC_B_PE         = 13;

    // Trips, first field is the top bit
    typedef struct packed {
        logic current_detect_trip;
        logic input_phase_loss_trip;
        logic param_storage_trip;
        logic stall_prevention_trip;
        logic ptc_thermal_trip;
        logic heatsink_thermal_trip;
        logic ground_fault_trip;
        logic brake_transistor_trip;
        logic inverter_thermal_trip;
        logic motor_thermal_trip;
        logic decel_overvoltage_trip;
        logic const_speed_overvoltage_trip;
        logic accel_overvoltage_trip;
        logic decel_overcurrent_trip;
        logic const_speed_overcurrent_trip;
        logic accel_overcurrent_trip;
    } frc_trip_t;

    // Settings from the parameter store
    typedef struct packed {
        logic [2:0]  retry_fault_class_select;
        logic [7:0]  retry_limit_setting;
        logic [12:0] retry_wait_time;
        logic [13:0] restart_coasting_setting;
        logic [7:0]  output_terminal_func;
    } frc_cfg_t;

    // Class masks
    localparam logic [15:0] FRC_MASK_ALL     = 16'hffff;
    localparam logic [15:0] FRC_MASK_OC      = 16'h0007;
    localparam logic [15:0] FRC_MASK_OV      = 16'h0038;
    localparam logic [15:0] FRC_MASK_OCOV    = 16'h003f;
    localparam logic [15:0] FRC_MASK_WIDE    = 16'hf33f;
    localparam logic [15:0] FRC_MASK_ACDC    = 16'h0005;

    // Trips that a class selection retries
    function automatic logic [15:0] frc_class_mask(input logic [2:0] sel);
        logic [15:0] m;
        m = 16'h0000;
        unique case (sel)
            3'h0:    m = FRC_MASK_ALL;
            3'h1:    m = FRC_MASK_OC;
            3'h2:    m = FRC_MASK_OV;
            3'h3:    m = FRC_MASK_OCOV;
            3'h4:    m = FRC_MASK_WIDE;
            3'h5:    m = FRC_MASK_ACDC;
            default: m = 16'h0000;
        endcase
        return m;
    endfunction

endpackage

// >>> design/frc_retry_ctrl.sv
// Fault retry controller: qualifies trips, waits, clears, restarts, counts.
// Assumes trip inputs synchronous to i_clk_sys and held until o_fault_clear.
`timescale 1ns/1ps

//Function
//- After the wait expires, clear the fault and restart at starting frequency.
//- A retry limit setting of zero disables retrying.
//- Setting 1 to 10 is the limit; fault output stays off while retrying.
//- Setting above 100 gives limit setting minus 100; fault output on during the retry wait, off after the restart.
//- Failed retries reaching the limit raise the excess trip and lock.
//- Wait from shutoff to retry is 0.1 s to 600 s, default 1 s.
//- Fault-free run over four waits after restart bumps the success count.
//- A successful retry clears the consecutive failure count.
//- The success count is readable as the display setting.
//- Writing zero to the display setting clears the success count.
//- Retry-active output on during retry; terminal code 64 or inverted 164.
//- Class selection 0 to 5 picks retried trips; others are not retried.
//- Class table maps each selection to its set of trips.
//- Only the first fault of a retry sequence is recorded.
//- Retry reset keeps thermal and brake duty data; power-on reset clears them.
//- Storage fault seen at power-on is never retried.
//- Out-of-class trip during the wait stops retry and keeps fault shown.
//- With coasting restart enabled, retry uses the flying restart procedure.
//- Trips during offline auto tuning are never retried; the code does not check this during the wait.
module frc_retry_ctrl
    import frc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = FRC_TICK_CYCLES
) (
    // Clock, reset, enable
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    input  wire logic             i_en,
    // Fault detectors and drive status
    input  wire frc_pkg::frc_trip_t i_trip,
    input  wire logic             i_pe_at_power_on,
    input  wire logic             i_autotune_active,
    input  wire logic             i_fault_reset,
    // Settings
    input  wire frc_pkg::frc_cfg_t i_cfg,
    input  wire logic             i_count_clear,
    // Output stage control
    output logic                  o_fault_clear,
    output logic                  o_restart,
    output logic                  o_flying_restart,
    output logic                  o_fault_out,
    output logic                  o_excess_trip,
    // Status
    output logic                  o_retry_active,
    output logic                  o_term_retry,
    output logic [15:0]           o_success_count,
    output logic [7:0]            o_fail_count,
    output frc_pkg::frc_trip_t    o_first_fault
);
    import frc_pkg::*;

    localparam int unsigned PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRESC_LAST = PW'(TICK_CYCLES - 1);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_WATCH,
        ST_LOCKED
    } frc_state_t;

    frc_state_t        state;
    frc_state_t        next_state;
    logic [PW-1:0]     presc;
    logic [PW-1:0]     next_presc;
    logic [14:0]       ticks;
    logic [14:0]       next_ticks;
    logic [15:0]       trip_q;
    logic [7:0]        lim_set_q;
    logic [7:0]        next_lim_set_q;
    logic [15:0]       next_success_count;
    logic [7:0]        next_fail_count;
    logic [15:0]       next_first_fault;
    logic              next_fault_clear;
    logic              next_restart;
    logic              next_flying_restart;
    logic              next_fault_out;
    logic              next_excess_trip;
    logic              next_retry_active;
    logic              next_term_retry;

    logic [15:0]       trip_vec;
    logic [15:0]       rise;
    logic [15:0]       mask_eff;
    logic              any_rise;
    logic              in_class;
    logic              out_class;
    logic [7:0]        limit;
    logic [7:0]        limit_q;
    logic [12:0]       wait_eff;
    logic              wait_done;
    logic              success_now;
    logic              fail_reach;
    logic              tick;

    // Trip qualification
    always_comb begin
        trip_vec  = i_trip;
        rise      = trip_vec & ~trip_q;
        any_rise  = |rise;
        mask_eff  = frc_class_mask(i_cfg.retry_fault_class_select);
        if (i_pe_at_power_on) begin
            mask_eff[FRC_B_PE] = 1'b0;
        end
        in_class  = |(rise & mask_eff);
        out_class = |(rise & ~mask_eff);
    end

    // Retry limit from a count setting
    function automatic logic [7:0] frc_limit_of(input logic [7:0] setting);
        if (setting > FRC_LIMIT_OFFSET) begin
            return setting - FRC_LIMIT_OFFSET;
        end
        return setting;
    endfunction

    // Limit, wait and window decode
    always_comb begin
        limit       = frc_limit_of(i_cfg.retry_limit_setting);
        limit_q     = frc_limit_of(lim_set_q);
        if (i_cfg.retry_wait_time < FRC_WAIT_MIN) begin
            wait_eff = FRC_WAIT_MIN;
        end else if (i_cfg.retry_wait_time > FRC_WAIT_MAX) begin
            wait_eff = FRC_WAIT_MAX;
        end else begin
            wait_eff = i_cfg.retry_wait_time;
        end
        tick        = (presc == PRESC_LAST);
        wait_done   = (ticks >= {2'b00, wait_eff});
        success_now = (state == ST_WATCH) && !any_rise
                      && (ticks > {wait_eff, 2'b00});
        fail_reach  = ({1'b0, o_fail_count} + 9'h001) >= {1'b0, limit_q};
    end

    // Sequencer next values
    always_comb begin
        next_state          = state;
        next_presc          = presc;
        next_ticks          = ticks;
        next_lim_set_q      = lim_set_q;
        next_fail_count     = o_fail_count;
        next_first_fault    = o_first_fault;
        next_fault_clear    = 1'b0;
        next_restart        = 1'b0;
        next_flying_restart = o_flying_restart;
        next_excess_trip    = o_excess_trip;
        unique case (state)
            ST_IDLE: begin
                if (any_rise) begin
                    next_first_fault = rise;
                    next_lim_set_q   = i_cfg.retry_limit_setting;
                    if ((limit != 8'h00) && !i_autotune_active
                        && in_class && !out_class) begin
                        next_state      = ST_WAIT;
                        next_fail_count = 8'h00;
                    end else begin
                        next_state = ST_LOCKED;
                    end
                    next_presc = '0;
                    next_ticks = 15'h0000;
                end
            end
            ST_WAIT: begin
                if (out_class) begin
                    next_state = ST_LOCKED;
                end else if (wait_done) begin
                    next_state          = ST_WATCH;
                    next_fault_clear    = 1'b1;
                    next_restart        = 1'b1;
                    next_flying_restart = (i_cfg.restart_coasting_setting
                                           != FRC_COAST_OFF);
                    next_presc          = '0;
                    next_ticks          = 15'h0000;
                end
            end
            ST_WATCH: begin
                if (any_rise) begin
                    next_fail_count = o_fail_count + 8'h01;
                    next_presc      = '0;
                    next_ticks      = 15'h0000;
                    if (fail_reach) begin
                        next_state       = ST_LOCKED;
                        next_excess_trip = 1'b1;
                    end else if (in_class && !out_class && !i_autotune_active) begin
                        next_state = ST_WAIT;
                    end else begin
                        next_state = ST_LOCKED;
                    end
                end else if (success_now) begin
                    next_state      = ST_IDLE;
                    next_fail_count = 8'h00;
                end
            end
            ST_LOCKED: begin
                if (i_fault_reset) begin
                    next_state       = ST_IDLE;
                    next_fail_count  = 8'h00;
                    next_excess_trip = 1'b0;
                    next_fault_clear = 1'b1;
                end
            end
        endcase
        if ((next_state == ST_WAIT || next_state == ST_WATCH) && next_state == state) begin
            if (tick) begin
                next_presc = '0;
                if (ticks != FRC_TICKS_MAX) begin
                    next_ticks = ticks + 15'h0001;
                end
            end else begin
                next_presc = presc + PW'(1);
            end
        end
    end

    // Output decode
    always_comb begin
        next_success_count = (i_count_clear ? 16'h0000 : o_success_count)
                             + {15'h0000, success_now};
        next_retry_active  = (next_state == ST_WAIT) || (next_state == ST_WATCH);
        if (next_state == ST_LOCKED) begin
            next_fault_out = 1'b1;
        end else if (next_state == ST_WAIT) begin
            next_fault_out = (next_lim_set_q > FRC_LIMIT_OFFSET);
        end else begin
            next_fault_out = 1'b0;
        end
        if (i_cfg.output_terminal_func == FRC_FUNC_POS) begin
            next_term_retry = next_retry_active;
        end else if (i_cfg.output_terminal_func == FRC_FUNC_NEG) begin
            next_term_retry = !next_retry_active;
        end else begin
            next_term_retry = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state            <= ST_IDLE;
            presc            <= '0;
            ticks            <= 15'h0000;
            trip_q           <= 16'h0000;
            lim_set_q        <= 8'h00;
            o_success_count  <= 16'h0000;
            o_fail_count     <= 8'h00;
            o_first_fault    <= 16'h0000;
            o_fault_clear    <= 1'b0;
            o_restart        <= 1'b0;
            o_flying_restart <= 1'b0;
            o_fault_out      <= 1'b0;
            o_excess_trip    <= 1'b0;
            o_retry_active   <= 1'b0;
            o_term_retry     <= 1'b0;
        end else if (i_en) begin
            state            <= next_state;
            presc            <= next_presc;
            ticks            <= next_ticks;
            trip_q           <= trip_vec;
            lim_set_q        <= next_lim_set_q;
            o_success_count  <= next_success_count;
            o_fail_count     <= next_fail_count;
            o_first_fault    <= next_first_fault;
            o_fault_clear    <= next_fault_clear;
            o_restart        <= next_restart;
            o_flying_restart <= next_flying_restart;
            o_fault_out      <= next_fault_out;
            o_excess_trip    <= next_excess_trip;
            o_retry_active   <= next_retry_active;
            o_term_retry     <= next_term_retry;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    property p_restart_after_wait;
        (i_en && state == ST_WAIT && !out_class && wait_done)
            |=> (o_restart && o_fault_clear && state == ST_WATCH);
    endproperty
    a_restart_after_wait: assert property (p_restart_after_wait)
        else $error("Restart did not follow the expired wait");

    property p_zero_limit;
        (i_en && state == ST_IDLE && any_rise && limit == 8'h00)
            |=> (state == ST_LOCKED && !o_retry_active);
    endproperty
    a_zero_limit: assert property (p_zero_limit)
        else $error("Retry started with a zero limit");

    property p_quiet_fault;
        (state == ST_WAIT && lim_set_q <= FRC_LIMIT_QUIET) |-> !o_fault_out;
    endproperty
    a_quiet_fault: assert property (p_quiet_fault)
        else $error("Fault output shown during quiet retry");

    property p_loud_fault;
        (state == ST_WAIT && lim_set_q > FRC_LIMIT_OFFSET) |-> o_fault_out;
    endproperty
    a_loud_fault: assert property (p_loud_fault)
        else $error("Fault output missing during retry");

    property p_excess;
        (i_en && state == ST_WATCH && any_rise && fail_reach)
            |=> (state == ST_LOCKED && o_excess_trip && o_fault_out);
    endproperty
    a_excess: assert property (p_excess)
        else $error("Excess retry trip not raised");

    property p_success;
        (i_en && success_now && !i_count_clear)
            |=> (o_success_count == $past(o_success_count) + 16'h0001);
    endproperty
    a_success: assert property (p_success)
        else $error("Success count did not step by one");

    property p_fail_clear;
        (i_en && success_now) |=> (o_fail_count == 8'h00 && state == ST_IDLE);
    endproperty
    a_fail_clear: assert property (p_fail_clear)
        else $error("Failure count kept after success");

    property p_count_clear;
        (i_en && i_count_clear && !success_now) |=> (o_success_count == 16'h0000);
    endproperty
    a_count_clear: assert property (p_count_clear)
        else $error("Success count not cleared");

    property p_out_class;
        (i_en && state == ST_WAIT && out_class) |=> (state == ST_LOCKED && o_fault_out);
    endproperty
    a_out_class: assert property (p_out_class)
        else $error("Retry continued after out-of-class trip");

    property p_pe_power_on;
        (i_en && state == ST_IDLE && rise[FRC_B_PE] && i_pe_at_power_on)
            |=> (state != ST_WAIT);
    endproperty
    a_pe_power_on: assert property (p_pe_power_on)
        else $error("Power-on storage fault was retried");

    property p_autotune;
        (i_en && state == ST_IDLE && any_rise && i_autotune_active)
            |=> (state == ST_LOCKED);
    endproperty
    a_autotune: assert property (p_autotune)
        else $error("Retry started during auto tuning");

endmodule // frc_retry_ctrl

// >>> verif/frc_det_model.sv
// Fault detector model: each raised trip is held until the controller clears it.
// Assumes raise requests from the bench arrive just after a rising clock edge.
`timescale 1ns/1ps
module frc_det_model
    import frc_pkg::*;
(
    // Clock and reset
    input  wire logic          i_clk_sys,
    input  wire logic          i_rst_n,
    // Raise requests and clear from the controller
    input  wire logic [15:0]   i_raise,
    input  wire logic          i_fault_clear,
    // Trip levels
    output frc_pkg::frc_trip_t o_trip
);
    import frc_pkg::*;

    // A retry reset drops every held trip; power-on reset too
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_trip <= '0;
        end else if (i_fault_clear) begin
            o_trip <= frc_trip_t'(i_raise);
        end else begin
            o_trip <= frc_trip_t'(o_trip | i_raise);
        end
    end
endmodule // frc_det_model

// >>> verif/tb.sv
// Testbench for the fault retry controller, with a detector model on its far side.
// Assumes a 250 MHz clock and a shortened tick of 4 cycles.
`timescale 1ns/1ps
module tb;
    import frc_pkg::*;
    logic        clk_sys, rst_n, en, fault_reset, pe_on, tune, count_clear;
    logic [15:0] raise, succ;
    logic [7:0]  fails;
    frc_cfg_t    cfg;
    frc_trip_t   trip, first;
    logic        fault_clear, restart, flying, fault_out, excess, active, term;
    int          error_cnt, num_checks;

    frc_det_model i_det (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_raise(raise),
                         .i_fault_clear(fault_clear), .o_trip(trip));
    frc_retry_ctrl #(.TICK_CYCLES(4)) i_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
        .i_en(en), .i_trip(trip), .i_pe_at_power_on(pe_on), .i_autotune_active(tune),
        .i_fault_reset(fault_reset), .i_cfg(cfg), .i_count_clear(count_clear),
        .o_fault_clear(fault_clear), .o_restart(restart), .o_flying_restart(flying),
        .o_fault_out(fault_out), .o_excess_trip(excess), .o_retry_active(active),
        .o_term_retry(term), .o_success_count(succ), .o_fail_count(fails),
        .o_first_fault(first));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic boot(input logic [2:0] sel, input logic [7:0] lim, input logic [12:0] w);
        rst_n = 1'b0;
        cfg = '{sel, lim, w, 14'h270f, 8'h40};
        step(2);
        rst_n = 1'b1;
        step(1);
    endtask

    task automatic hit(input int b);
        raise = 16'h0001 << b;
        step(1);
        raise = '0;
        step(2);
    endtask

    task automatic wait_restart(output int n);
        n = 0;
        while (restart !== 1'b1 && n < 400) begin
            step(1);
            n++;
        end
    endtask

    task automatic t_success();
        int n;
        boot(3'h0, 8'h03, 13'h0001);
        hit(0);
        chk(active, 1'b1);
        chk(fault_out, 1'b0);
        chk(first, 16'h0001);
        wait_restart(n);
        chk(restart, 1'b1);
        chk(fault_clear, 1'b1);
        step(1);
        chk(restart, 1'b0);
        chk(flying, 1'b0);
        step(1);
        hit(1);
        chk(fails, 8'h01);
        chk(first, 16'h0001);
        wait_restart(n);
        step(17);
        chk(active, 1'b1);
        chk(succ, 16'h0);
        step(4);
        chk(succ, 16'h1);
        chk(fails, 8'h00);
        chk(active, 1'b0);
        count_clear = 1'b1;
        step(1);
        count_clear = 1'b0;
        step(1);
        chk(succ, 16'h0);
    endtask

    task automatic t_wait();
        int n0;
        int n1;
        int n3;
        int nf;
        boot(3'h0, 8'h03, 13'h0001);
        hit(0);
        wait_restart(n1);
        boot(3'h0, 8'h03, 13'h0003);
        hit(0);
        wait_restart(n3);
        boot(3'h0, 8'h03, 13'h0000);
        hit(0);
        wait_restart(n0);
        chk(16'(n3 - n1), 16'h0008);
        chk(16'(n0), 16'(n1));
        boot(3'h0, 8'h03, 13'h0001);
        hit(0);
        en = 1'b0;
        step(8);
        en = 1'b1;
        wait_restart(nf);
        chk(16'(nf), 16'(n1));
    endtask

    task automatic t_excess(input logic [7:0] setting, input int lim, input logic fo);
        int n;
        boot(3'h0, setting, 13'h0001);
        hit(0);
        chk(fault_out, fo);
        for (int i = 1; i <= lim; i++) begin
            chk(excess, 1'b0);
            wait_restart(n);
            step(2);
            hit(0);
        end
        chk(excess, 1'b1);
        chk(fails, 8'(lim));
        chk(active, 1'b0);
        fault_reset = 1'b1;
        step(1);
        fault_reset = 1'b0;
        step(2);
        chk(excess, 1'b0);
    endtask

    task automatic t_classes();
        logic [15:0] m [6];
        m = '{16'hffff, 16'h0007, 16'h0038, 16'h003f, 16'hf33f, 16'h0005};
        for (int s = 0; s < 6; s++) begin
            for (int b = 0; b < 16; b++) begin
                boot(3'(s), 8'h03, 13'h0001);
                hit(b);
                chk(active, m[s][b]);
            end
        end
        boot(3'h0, 8'h03, 13'h0001);
        pe_on = 1'b1;
        hit(13);
        chk(active, 1'b0);
        pe_on = 1'b0;
        tune = 1'b1;
        boot(3'h0, 8'h03, 13'h0001);
        hit(0);
        chk(active, 1'b0);
        tune = 1'b0;
        boot(3'h0, 8'h00, 13'h0001);
        hit(0);
        chk(active, 1'b0);
    endtask

    task automatic t_outclass();
        int n;
        boot(3'h1, 8'h03, 13'h0003);
        hit(0);
        hit(1);
        chk(first, 16'h0001);
        chk(active, 1'b1);
        hit(3);
        chk(active, 1'b0);
        chk(fault_out, 1'b1);
        wait_restart(n);
        chk(16'(n), 16'd400);
    endtask

    task automatic t_term_fly();
        int n;
        boot(3'h0, 8'h03, 13'h0001);
        cfg.output_terminal_func = 8'ha4;
        cfg.restart_coasting_setting = 14'h0005;
        step(2);
        chk(term, 1'b1);
        hit(0);
        chk(term, 1'b0);
        wait_restart(n);
        step(1);
        chk(flying, 1'b1);
        cfg.output_terminal_func = 8'h40;
        step(2);
        chk(term, 1'b1);
        cfg.output_terminal_func = 8'h00;
        step(2);
        chk(term, 1'b0);
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #80000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        rst_n = 1'b0;
        en = 1'b1;
        raise = '0;
        fault_reset = 1'b0;
        pe_on = 1'b0;
        tune = 1'b0;
        count_clear = 1'b0;
        cfg = '{3'h0, 8'h03, 13'h0001, 14'h270f, 8'h40};
        step(20);
        rst_n = 1'b1;
        step(1);
        t_success();
        t_wait();
        t_excess(8'h02, 2, 1'b0);
        t_excess(8'h0a, 10, 1'b0);
        t_excess(8'h65, 1, 1'b1);
        t_excess(8'h66, 2, 1'b1);
        t_classes();
        t_outclass();
        t_term_fly();
        give_verdict();
    end
endmodule // tb
